// >>> common/ufl_params.svh
// timing counts and field constants for the usb fifo byte to led reader
`ifndef UFL_PARAMS_SVH
`define UFL_PARAMS_SVH
`define UFL_FIFO_SEL_EP0 2'h0
`define UFL_SEQ_BYTE 8'h05
`define UFL_LED_RESET 4'h0
`define UFL_STEP_TIME_MS 250
`define UFL_CLK_MHZ 100
`define UFL_STEP_CYCLES (`UFL_STEP_TIME_MS * 1000 * `UFL_CLK_MHZ)
`endif

// >>> common/ufl_pkg.sv
// types for the usb fifo byte to led reader
package ufl_pkg;
    typedef enum logic [1:0] {
        UFL_IDLE = 2'b00,
        UFL_READ = 2'b01,
        UFL_RELEASE = 2'b10
    } ufl_state_t;

    typedef struct packed {
        logic [1:0] fifo_select;
        logic slave_output_enable_n;
        logic slave_read_strobe_n;
    } ufl_ctl_t;
endpackage

// >>> logic/ufl_led_stepper.sv
// walking led pattern for the sequence byte
`timescale 1ns/1ps
`include "ufl_params.svh"
module ufl_led_stepper
    import ufl_pkg::*;
#(
    parameter int STEP_CYCLES = `UFL_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic run,
    output logic [3:0] pattern
);
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic [3:0] pattern_r;
    logic [3:0] pattern_nxt;

    always_comb begin
        count_nxt = count_r;
        pattern_nxt = pattern_r;
        if (!run) begin
            count_nxt = 32'h0;
            pattern_nxt = 4'h1;
        end else if (count_r >= 32'(STEP_CYCLES - 1)) begin
            count_nxt = 32'h0;
            pattern_nxt = {pattern_r[2:0], pattern_r[3]};
        end else begin
            count_nxt = count_r + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_r <= 32'h0;
            pattern_r <= 4'h1;
        end else if (clock_enable) begin
            count_r <= count_nxt;
            pattern_r <= pattern_nxt;
        end
    end

    assign pattern = pattern_r;
endmodule // ufl_led_stepper

// >>> logic/ufl_reader.sv
// reads single bytes from the usb controller fifo and shows them on leds
`timescale 1ns/1ps
`include "ufl_params.svh"
module ufl_reader
    import ufl_pkg::*;
#(
    parameter int STEP_CYCLES = `UFL_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic fifo_empty_flag_n,
    input wire logic [7:0] fifo_byte_bus,
    output logic [1:0] fifo_select,
    output logic slave_output_enable_n,
    output logic slave_read_strobe_n,
    output logic [3:0] led
);
    ////////////////////////////////////////////////////////////////////////
    // state and next values
    ufl_state_t state_r;
    ufl_state_t state_nxt;
    ufl_ctl_t ctl_r;
    ufl_ctl_t ctl_nxt;
    logic [7:0] byte_r;
    logic [7:0] byte_nxt;
    logic load_led_r;
    logic load_led_nxt;
    logic [3:0] led_r;
    logic [3:0] led_nxt;
    logic [3:0] step_pattern;
    logic seq_mode;
    logic byte_waiting;
    logic start_read;
    logic in_read;

    ////////////////////////////////////////////////////////////////////////
    // read decode
    // flag high means a byte waits in the fifo
    assign byte_waiting = fifo_empty_flag_n;
    // flag only counts while idle; read and release ignore it
    assign start_read = (state_r == UFL_IDLE) && byte_waiting;
    assign in_read = (state_r == UFL_READ);

    ////////////////////////////////////////////////////////////////////////
    // read sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            UFL_IDLE: begin
                if (start_read) begin
                    state_nxt = UFL_READ;
                end
            end
            UFL_READ: begin
                state_nxt = UFL_RELEASE;
            end
            UFL_RELEASE: begin
                // one cycle for the flag to settle after the strobe
                state_nxt = UFL_IDLE;
            end
            default: begin
                state_nxt = UFL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r <= UFL_IDLE;
        end else if (clock_enable) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fifo controls
    always_comb begin
        ctl_nxt = ctl_r;
        ctl_nxt.fifo_select = `UFL_FIFO_SEL_EP0;
        if (start_read) begin
            ctl_nxt.slave_output_enable_n = 1'b0;
            ctl_nxt.slave_read_strobe_n = 1'b0;
        end else begin
            // strobe and enable low for one cycle only
            ctl_nxt.slave_output_enable_n = 1'b1;
            ctl_nxt.slave_read_strobe_n = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ctl_r.fifo_select <= `UFL_FIFO_SEL_EP0;
            ctl_r.slave_output_enable_n <= 1'b1;
            ctl_r.slave_read_strobe_n <= 1'b1;
        end else if (clock_enable) begin
            ctl_r <= ctl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte capture
    always_comb begin
        byte_nxt = byte_r;
        load_led_nxt = in_read;
        if (in_read) begin
            // bus is driven while the enable is low
            byte_nxt = fifo_byte_bus;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            byte_r <= 8'h00;
            load_led_r <= 1'b0;
        end else if (clock_enable) begin
            byte_r <= byte_nxt;
            load_led_r <= load_led_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // led drive
    assign seq_mode = (byte_r == `UFL_SEQ_BYTE);

    ufl_led_stepper #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_stepper (
        .clock(clock),
        .reset_n(reset_n),
        .clock_enable(clock_enable),
        .run(seq_mode),
        .pattern(step_pattern)
    );

    always_comb begin
        led_nxt = led_r;
        if (seq_mode) begin
            led_nxt = step_pattern;
        end else if (load_led_r) begin
            // new nibble shows one cycle after capture
            led_nxt = byte_r[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            led_r <= `UFL_LED_RESET;
        end else if (clock_enable) begin
            led_r <= led_nxt;
        end
    end

    assign fifo_select = ctl_r.fifo_select;
    assign slave_output_enable_n = ctl_r.slave_output_enable_n;
    assign slave_read_strobe_n = ctl_r.slave_read_strobe_n;
    assign led = led_r;
endmodule // ufl_reader

// >>> testbench/ufl_reader_sva.sv
// port checker for the fifo reader
`timescale 1ns/1ps
module ufl_reader_sva (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic fifo_empty_flag_n,
    input wire logic [7:0] fifo_byte_bus,
    input wire logic [1:0] fifo_select,
    input wire logic slave_output_enable_n,
    input wire logic slave_read_strobe_n,
    input wire logic [3:0] led
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sel_zero_a: assert property (fifo_select == 2'h0) else $error("bad select");
    read_cause_a: assert property ($fell(slave_read_strobe_n) |->
        $past(fifo_empty_flag_n)) else $error("read with no data");
    one_read_a: assert property (!slave_read_strobe_n |-> !slave_output_enable_n
        ##1 slave_read_strobe_n && slave_output_enable_n) else $error("long read");
    led_show_a: assert property ($rose(slave_read_strobe_n) |=> led ==
        ($past(fifo_byte_bus, 2) == 8'h05 ? 4'h1 : $past(fifo_byte_bus[3:0], 2)))
        else $error("bad led");
    release_gap_a: assert property ($rose(slave_read_strobe_n) |->
        slave_read_strobe_n [*2]) else $error("strobe too soon");
endmodule // ufl_reader_sva
bind ufl_reader ufl_reader_sva u_sva (.*);

// >>> testbench/ufl_fifo_model.sv
// one byte slot model of the controller fifo
`timescale 1ns/1ps
module ufl_fifo_model (
    input wire logic clock,
    input wire logic put,
    input wire logic [7:0] pb,
    input wire logic oe_n,
    input wire logic rd_n,
    output logic fl_n,
    output logic [7:0] bus
);
    logic full_r = 1'b0;
    logic [7:0] data_r = 8'h00;
    always @(posedge clock) begin
        if (put) begin
            full_r <= 1'b1;
            data_r <= pb;
        end else if (!rd_n) begin
            full_r <= 1'b0;
        end
    end
    assign fl_n = full_r;
    assign bus = oe_n ? ~data_r : data_r;
endmodule // ufl_fifo_model

// >>> testbench/ufl_reader_test.sv
// bench for the fifo byte to led reader
`timescale 1ns/1ps
module ufl_reader_test;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic put = 1'b0;
    logic clock_enable = 1'b1;
    logic [1:0] sel;
    logic [7:0] pb = 8'h00;
    logic fl_n, oe_n, rd_n;
    logic [7:0] bus;
    logic [3:0] led;
    int bad_count = 0;
    int check_count = 0;
    always #5 clock = ~clock;
    ufl_reader #(.STEP_CYCLES(4)) DUT (.clock(clock), .reset_n(reset_n),
        .clock_enable(clock_enable), .fifo_empty_flag_n(fl_n), .fifo_byte_bus(bus),
        .fifo_select(sel), .slave_output_enable_n(oe_n), .slave_read_strobe_n(rd_n), .led(led));
    ufl_fifo_model far (.clock(clock), .put(put), .pb(pb), .oe_n(oe_n), .rd_n(rd_n),
        .fl_n(fl_n), .bus(bus));
    task test_done;
        $display("checks %0d bad %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(logic [3:0] seen, logic [3:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t led %h", $time, seen);
        end
    endtask
    task send(logic [7:0] b);
        int reads;
        reads = 0;
        @(posedge clock);
        put <= 1'b1;
        pb <= b;
        @(posedge clock);
        put <= 1'b0;
        repeat (6) begin
            @(posedge clock);
            if (rd_n === 1'b0) reads++;
        end
        chk(4'(reads), 4'h1);
    endtask
    task wait_led(logic [3:0] want);
        int n;
        n = 0;
        while (led !== want && n < 20) begin
            @(negedge clock);
            n++;
        end
        chk(led, want);
        if (led !== want) test_done;
    endtask
    task t_nibble;
        logic [7:0] v[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'hfa, 8'h00};
        foreach (v[i]) begin
            send(v[i]);
            chk(led, v[i][3:0]);
            chk({sel, oe_n, rd_n}, 4'h3);
        end
        $display("nibble test done");
    endtask
    task t_walk;
        logic [3:0] w;
        w = 4'h1;
        send(8'h05);
        repeat (6) begin
            wait_led(w);
            w = {w[2:0], w[3]};
        end
        send(8'h0c);
        chk(led, 4'hc);
        $display("walk test done");
    endtask
    task t_freeze;
        @(posedge clock);
        clock_enable <= 1'b0;
        put <= 1'b1;
        pb <= 8'h09;
        @(posedge clock);
        put <= 1'b0;
        repeat (6) @(posedge clock);
        chk(led, 4'hc);
        chk({2'h0, oe_n, rd_n}, 4'h3);
        clock_enable <= 1'b1;
        wait_led(4'h9);
        $display("freeze test done");
    endtask
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        t_nibble;
        t_walk;
        t_freeze;
        test_done;
    end
endmodule // ufl_reader_test
